// ### core/tcc_timer.sv
/*
 * 16-bit timer/event counter with interval, pulse output and capture modes,
 * plus the port-3 direction register that routes the timer output pin.
 * Assumes edge inputs are asynchronous and the CPU port is synchronous.
 */
// Behaviour
// - Reset loads port-3 direction with all ones, all pins input.
// - Low five direction bits: 0 drives pin, 1 releases; bits 7..5 read 1.
// - Interval mode clears count on match with A and pulses match-A request.
// - Clock select field sits in bits 1..0 of the prescale mode register.
// - Codes 00..11 give fx, fx/4, fx/64, input-A valid edges.
// - Edge codes: 00 falling, 01 rising, 10 prohibited, 11 both.
// - Pulse mode: period from register A, width from register B.
// - Period is A+1 counts, active part B+1 counts.
// - Free-running: valid input-A edge captures count into B, pulses request.
// - Input-A valid edge chosen by bits 5..4.
// - Inputs sampled at count clock, or at fx/8 when input A is the count clock; level must hold two samples.
// - Input-B edge per bits 7..6 captures into A and pulses match-A.
// - Two-register capture: opposite input-A edge captures into A.
// - Two-register capture with both edges selected on input A: register A never captures.
// - Two-register capture loads register A only with rising or falling selected on input A.
`timescale 1ns/1ps
module tcc_timer (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// CPU register port
	input  wire logic [15:0] addr,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [15:0] wr_data,
	output logic      [15:0] rd_data,
	// Edge input pins
	input  wire logic        edge_input_a,
	input  wire logic        edge_input_b,
	// Timer output pin and port-3 buffers
	output logic             timer_out_pin,
	output logic      [4:0]  port3_out_en,
	// Interrupt requests
	output logic             match_a_irq,
	output logic             capture_b_irq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0]        port3_direction_r, port3_direction_nxt;
	tcc_pkg::tcc_prm_t prescale_mode_reg_r, prescale_mode_reg_nxt;
	tcc_pkg::tcc_mode_t timer_mode_reg_r, timer_mode_reg_nxt;
	logic [2:0]        capture_ctrl_reg_r, capture_ctrl_reg_nxt;
	logic [15:0]       count_register_r, count_register_nxt;
	logic [15:0]       cmp_cap_reg_a_r, cmp_cap_reg_a_nxt;
	logic [15:0]       cmp_cap_reg_b_r, cmp_cap_reg_b_nxt;
	logic [5:0]        div_r, div_nxt;
	logic [1:0]        sync1_r, sync2_r, smp0_r, smp0_nxt, smp1_r, smp1_nxt;
	logic [1:0]        filt_r, filt_nxt;
	logic              out_r, out_nxt, irq_a_r, irq_a_nxt, irq_b_r, irq_b_nxt;
	logic [15:0]       rd_r, rd_nxt;
	logic [4:0]        oe_r, oe_nxt;
	logic              div_tick, sample_en, count_en, running;
	tcc_pkg::tcc_edge_t edge_a, edge_b;
	logic              valid_a, valid_b, rev_a;

	// ------------------------------------------------------------
	// Prescaler and sampling enables
	// ------------------------------------------------------------
	// Divider tick and sample enable for the selected count clock
	always_comb begin
		div_nxt = 6'(div_r + 6'h01);
		case (prescale_mode_reg_r.clk_sel)
			tcc_pkg::CLK_FX:   div_tick = 1'b1;
			tcc_pkg::CLK_FX4:  div_tick = (div_r & tcc_pkg::DIV4_MASK) == tcc_pkg::DIV4_MASK;
			tcc_pkg::CLK_FX64: div_tick = div_r == tcc_pkg::DIV64_MASK;
			default:           div_tick = (div_r & tcc_pkg::DIV8_MASK) == tcc_pkg::DIV8_MASK;
		endcase
		running   = timer_mode_reg_r != tcc_pkg::MODE_STOP;
		sample_en = running && div_tick;
	end

	// ------------------------------------------------------------
	// Edge inputs: synchroniser, two-sample filter, edge decode
	// ------------------------------------------------------------
	// Filtered level only moves after two equal samples
	always_comb begin
		smp0_nxt = smp0_r;
		smp1_nxt = smp1_r;
		filt_nxt = filt_r;
		if (sample_en) begin
			smp0_nxt = sync2_r;
			smp1_nxt = smp0_r;
			for (int i = 0; i < 2; i++) begin
				if (smp0_nxt[i] == smp1_nxt[i]) begin
					filt_nxt[i] = smp0_nxt[i];
				end
			end
		end
		edge_a.rise = filt_nxt[0] & ~filt_r[0];
		edge_a.fall = ~filt_nxt[0] & filt_r[0];
		edge_b.rise = filt_nxt[1] & ~filt_r[1];
		edge_b.fall = ~filt_nxt[1] & filt_r[1];
	end

	// Valid edge decode per selection field
	always_comb begin
		case (prescale_mode_reg_r.es_a)
			tcc_pkg::EDGE_FALL: begin
				valid_a = edge_a.fall;
				rev_a   = edge_a.rise;
			end
			tcc_pkg::EDGE_RISE: begin
				valid_a = edge_a.rise;
				rev_a   = edge_a.fall;
			end
			tcc_pkg::EDGE_BOTH: begin
				valid_a = edge_a.rise | edge_a.fall;
				rev_a   = 1'b0;
			end
			default: begin
				valid_a = 1'b0;
				rev_a   = 1'b0;
			end
		endcase
		case (prescale_mode_reg_r.es_b)
			tcc_pkg::EDGE_FALL: valid_b = edge_b.fall;
			tcc_pkg::EDGE_RISE: valid_b = edge_b.rise;
			tcc_pkg::EDGE_BOTH: valid_b = edge_b.rise | edge_b.fall;
			default:            valid_b = 1'b0;
		endcase
		if (prescale_mode_reg_r.clk_sel == tcc_pkg::CLK_EDGE_A) begin
			count_en = running && valid_a;
		end else begin
			count_en = sample_en;
		end
	end

	// ------------------------------------------------------------
	// Counter, compare, capture and output
	// ------------------------------------------------------------
	// Counter and capture/compare registers with CPU writes
	always_comb begin
		count_register_nxt = count_register_r;
		cmp_cap_reg_a_nxt  = cmp_cap_reg_a_r;
		cmp_cap_reg_b_nxt  = cmp_cap_reg_b_r;
		irq_a_nxt = 1'b0;
		irq_b_nxt = 1'b0;
		if (wr_en && addr == tcc_pkg::ADDR_CMP_A) begin
			cmp_cap_reg_a_nxt = wr_data;
		end else if (wr_en && addr == tcc_pkg::ADDR_CMP_B) begin
			cmp_cap_reg_b_nxt = wr_data;
		end
		if (!running) begin
			count_register_nxt = 16'h0000;
		end else if (count_en) begin
			if (timer_mode_reg_r != tcc_pkg::MODE_FREE
			    && count_register_r == cmp_cap_reg_a_r) begin
				count_register_nxt = 16'h0000;
				irq_a_nxt = 1'b1;
			end else begin
				count_register_nxt = 16'(count_register_r + 16'h0001);
			end
		end
		// Captures take priority over a CPU write in the same cycle
		if (running && capture_ctrl_reg_r[tcc_pkg::CAP_B_EN_BIT] && valid_a) begin
			cmp_cap_reg_b_nxt = count_register_r;
			irq_b_nxt = 1'b1;
		end
		if (running && capture_ctrl_reg_r[tcc_pkg::CAP_A_EN_BIT]) begin
			if (capture_ctrl_reg_r[tcc_pkg::CAP_A_REV_BIT] ? rev_a : valid_b) begin
				cmp_cap_reg_a_nxt = count_register_r;
				irq_a_nxt = !capture_ctrl_reg_r[tcc_pkg::CAP_A_REV_BIT];
			end
		end
		// Active while count is 0..B within each A+1 period
		out_nxt = timer_mode_reg_r == tcc_pkg::MODE_PULSE
		          && count_register_nxt <= cmp_cap_reg_b_r;
	end

	// ------------------------------------------------------------
	// Control registers and read port
	// ------------------------------------------------------------
	// CPU writes to control registers and read data selection
	always_comb begin
		port3_direction_nxt   = port3_direction_r;
		prescale_mode_reg_nxt = prescale_mode_reg_r;
		timer_mode_reg_nxt    = timer_mode_reg_r;
		capture_ctrl_reg_nxt  = capture_ctrl_reg_r;
		if (wr_en) begin
			if (addr == tcc_pkg::ADDR_PORT3_DIR) begin
				port3_direction_nxt = wr_data[7:0] | tcc_pkg::PORT3_FIXED;
			end else if (addr == tcc_pkg::ADDR_PRESCALE) begin
				prescale_mode_reg_nxt = tcc_pkg::tcc_prm_t'({wr_data[7:4], 2'h0, wr_data[1:0]});
			end else if (addr == tcc_pkg::ADDR_TIMER_MODE) begin
				timer_mode_reg_nxt = tcc_pkg::tcc_mode_t'(wr_data[1:0]);
			end else if (addr == tcc_pkg::ADDR_CAP_CTRL) begin
				capture_ctrl_reg_nxt = wr_data[2:0];
			end
		end
		oe_nxt = ~port3_direction_nxt[4:0];
		rd_nxt = rd_r;
		if (rd_en) begin
			if (addr == tcc_pkg::ADDR_PORT3_DIR) begin
				rd_nxt = {8'h00, port3_direction_r};
			end else if (addr == tcc_pkg::ADDR_PRESCALE) begin
				rd_nxt = {8'h00, prescale_mode_reg_r};
			end else if (addr == tcc_pkg::ADDR_TIMER_MODE) begin
				rd_nxt = {14'h0000, timer_mode_reg_r};
			end else if (addr == tcc_pkg::ADDR_CAP_CTRL) begin
				rd_nxt = {13'h0000, capture_ctrl_reg_r};
			end else if (addr == tcc_pkg::ADDR_COUNT) begin
				rd_nxt = count_register_r;
			end else if (addr == tcc_pkg::ADDR_CMP_A) begin
				rd_nxt = cmp_cap_reg_a_r;
			end else if (addr == tcc_pkg::ADDR_CMP_B) begin
				rd_nxt = cmp_cap_reg_b_r;
			end else begin
				rd_nxt = 16'h0000;
			end
		end
	end

	// Register everything; reset puts all pins to input
	always_ff @(posedge clock) begin
		sync1_r <= {edge_input_b, edge_input_a};
		sync2_r <= sync1_r;
		if (rst) begin
			port3_direction_r   <= tcc_pkg::PORT3_DIR_RST;
			oe_r                <= 5'h00;
			prescale_mode_reg_r <= tcc_pkg::tcc_prm_t'(tcc_pkg::PRESCALE_RST);
			timer_mode_reg_r    <= tcc_pkg::MODE_STOP;
			capture_ctrl_reg_r  <= tcc_pkg::CAP_CTRL_RST;
			count_register_r    <= 16'h0000;
			cmp_cap_reg_a_r     <= 16'h0000;
			cmp_cap_reg_b_r     <= 16'h0000;
			div_r  <= 6'h00;
			smp0_r <= 2'h0;
			smp1_r <= 2'h0;
			filt_r <= 2'h0;
			out_r  <= 1'b0;
			irq_a_r <= 1'b0;
			irq_b_r <= 1'b0;
			rd_r   <= 16'h0000;
		end else begin
			port3_direction_r   <= port3_direction_nxt;
			oe_r                <= oe_nxt;
			prescale_mode_reg_r <= prescale_mode_reg_nxt;
			timer_mode_reg_r    <= timer_mode_reg_nxt;
			capture_ctrl_reg_r  <= capture_ctrl_reg_nxt;
			count_register_r    <= count_register_nxt;
			cmp_cap_reg_a_r     <= cmp_cap_reg_a_nxt;
			cmp_cap_reg_b_r     <= cmp_cap_reg_b_nxt;
			div_r  <= div_nxt;
			smp0_r <= smp0_nxt;
			smp1_r <= smp1_nxt;
			filt_r <= filt_nxt;
			out_r  <= out_nxt;
			irq_a_r <= irq_a_nxt;
			irq_b_r <= irq_b_nxt;
			rd_r   <= rd_nxt;
		end
	end

	assign rd_data       = rd_r;
	assign timer_out_pin = out_r;
	assign port3_out_en  = oe_r;
	assign match_a_irq   = irq_a_r;
	assign capture_b_irq = irq_b_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_dir_high_bits: assert property (port3_direction_r[7:5] == 3'h7)
		else $error("direction bits 7..5 not one");
	a_dir_reset_val: assert property ($fell(rst) |-> port3_direction_r == 8'hFF)
		else $error("direction not FF after reset");
	a_oe_follows_dir: assert property (##1 oe_r == ~port3_direction_r[4:0])
		else $error("output enable disagrees with direction");
	a_interval_clear: assert property (count_en && running && timer_mode_reg_r ==
		tcc_pkg::MODE_INTERVAL && count_register_r == cmp_cap_reg_a_r
		&& !capture_ctrl_reg_r[0] |=> count_register_r == 16'h0000 && match_a_irq)
		else $error("interval match did not clear and request");
	a_free_wraps: assert property (count_en && timer_mode_reg_r == tcc_pkg::MODE_FREE
		&& count_register_r == 16'hFFFF |=> count_register_r == 16'h0000)
		else $error("free-running counter did not wrap");
	a_free_no_clear: assert property (count_en && timer_mode_reg_r == tcc_pkg::MODE_FREE
		&& count_register_r != 16'hFFFF |=> count_register_r == $past(count_register_r) + 16'h1)
		else $error("free-running counter skipped");
	a_cap_b_take: assert property (running && capture_ctrl_reg_r[2] && valid_a
		|=> cmp_cap_reg_b_r == $past(count_register_r) && capture_b_irq)
		else $error("input A capture into B missed");
	a_both_no_cap_a: assert property (capture_ctrl_reg_r[1:0] == 2'b11
		&& prescale_mode_reg_r.es_a == tcc_pkg::EDGE_BOTH && !(wr_en && addr ==
		tcc_pkg::ADDR_CMP_A) |=> $stable(cmp_cap_reg_a_r))
		else $error("register A captured with both edges");
	a_filter_two: assert property (filt_r != $past(filt_r) |-> smp0_r == smp1_r)
		else $error("filtered level moved without two samples");
	a_pulse_width: assert property (timer_mode_reg_r == tcc_pkg::MODE_PULSE
		&& $stable(timer_mode_reg_r) && $stable(cmp_cap_reg_b_r)
		|-> timer_out_pin == (count_register_r <= cmp_cap_reg_b_r))
		else $error("pulse output level wrong");
	a_fx4_spacing: assert property (prescale_mode_reg_r.clk_sel == tcc_pkg::CLK_FX4
		&& $stable(prescale_mode_reg_r) && sample_en |=> !sample_en [*3])
		else $error("fx/4 tick spacing wrong");

	c_interval_irq: cover property (timer_mode_reg_r == tcc_pkg::MODE_INTERVAL && match_a_irq);
	c_capture_b:    cover property (capture_b_irq);
	c_pulse_rise:   cover property ($rose(timer_out_pin));
	c_cap_a_rev:    cover property (capture_ctrl_reg_r[1:0] == 2'b11 && rev_a);
endmodule : tcc_timer

// ### include/tcc_pkg.sv
/*
 * Constants, field layouts and types of the 16-bit timer/capture block.
 * Assumes one 200 MHz system clock and a CPU port with 16-bit data.
 */
package tcc_pkg;
	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_PORT3_DIR  = 16'hFF23;
	localparam logic [15:0] ADDR_TIMER_MODE = 16'hFF60;
	localparam logic [15:0] ADDR_PRESCALE   = 16'hFF61;
	localparam logic [15:0] ADDR_CAP_CTRL   = 16'hFF62;
	localparam logic [15:0] ADDR_COUNT      = 16'hFF10;
	localparam logic [15:0] ADDR_CMP_A      = 16'hFF12;
	localparam logic [15:0] ADDR_CMP_B      = 16'hFF14;

	// ------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] PORT3_DIR_RST = 8'hFF;
	localparam logic [7:0] PORT3_FIXED   = 8'hE0;
	localparam logic [7:0] PRESCALE_RST  = 8'h00;
	localparam logic [2:0] CAP_CTRL_RST  = 3'h0;
	localparam int CAP_A_EN_BIT  = 0;
	localparam int CAP_A_REV_BIT = 1;
	localparam int CAP_B_EN_BIT  = 2;

	// ------------------------------------------------------------
	// Prescaler divider terminal counts
	// ------------------------------------------------------------
	localparam logic [5:0] DIV4_MASK  = 6'h03;
	localparam logic [5:0] DIV8_MASK  = 6'h07;
	localparam logic [5:0] DIV64_MASK = 6'h3F;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {CLK_FX, CLK_FX4, CLK_FX64, CLK_EDGE_A} tcc_clk_sel_t;
	typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_BAD, EDGE_BOTH} tcc_edge_sel_t;
	typedef enum logic [1:0] {MODE_STOP, MODE_FREE, MODE_INTERVAL, MODE_PULSE} tcc_mode_t;

	typedef struct packed {
		tcc_edge_sel_t es_b;
		tcc_edge_sel_t es_a;
		logic [1:0]    zero;
		tcc_clk_sel_t  clk_sel;
	} tcc_prm_t;

	typedef struct packed {
		logic rise;
		logic fall;
	} tcc_edge_t;
endpackage : tcc_pkg

// ### testbench/tb.sv
/*
 * Self-checking bench for the timer/capture block.
 * Assumes a 200 MHz clock and inputs driven on the falling edge.
 */
`timescale 1ns/1ps
module tb;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] exp;
	} tcc_row_t;
	logic        clock   = 1'b0;
	logic        rst     = 1'b1;
	logic [15:0] addr    = 16'h0000;
	logic        wr_en   = 1'b0;
	logic        rd_en   = 1'b0;
	logic [15:0] wr_data = 16'h0000;
	logic [15:0] rd_data;
	logic        edge_a;
	logic        edge_b;
	logic        tout;
	logic        irq_a;
	logic        irq_b;
	logic        prev;
	logic [4:0]  out_en;
	logic [15:0] v0;
	logic [15:0] v1;
	logic [15:0] exp_e [4];
	tcc_row_t    rows [7];
	int          div [3];
	int          cyc = 0;
	int          na = 0;
	int          nb = 0;
	int          err_total = 0;
	int          total_checks = 0;
	int          t0, t1, i, h, p, a0, b0;

	always #2.5 clock = ~clock;

	tcc_edge_src src (.edge_a(edge_a), .edge_b(edge_b));

	tcc_timer DUT (.clock(clock), .rst(rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
		.wr_data(wr_data), .rd_data(rd_data), .edge_input_a(edge_a),
		.edge_input_b(edge_b), .timer_out_pin(tout), .port3_out_en(out_en),
		.match_a_irq(irq_a), .capture_b_irq(irq_b));

	// Cycle and interrupt counters, hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (irq_a === 1'b1) na <= na + 1;
		if (irq_b === 1'b1) nb <= nb + 1;
		if (cyc == 10000) begin
			err_total++;
			finish_test();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One write strobe, then a quiet edge
	task wr(input logic [15:0] a, input logic [15:0] d);
		addr = a;
		wr_data = d;
		wr_en = 1'b1;
		@(negedge clock);
		wr_en = 1'b0;
		@(negedge clock);
	endtask : wr

	// Read data is taken one cycle after the strobe
	task rd(input logic [15:0] a, output logic [15:0] v);
		addr = a;
		rd_en = 1'b1;
		@(negedge clock);
		rd_en = 1'b0;
		@(negedge clock);
		v = rd_data;
	endtask : rd

	// Stop first, then configure and start
	task setup(input logic [7:0] prm, input logic [2:0] crc, input logic [1:0] mode);
		wr(tcc_pkg::ADDR_TIMER_MODE, 16'h0000);
		wr(tcc_pkg::ADDR_PRESCALE, {8'h00, prm});
		wr(tcc_pkg::ADDR_CAP_CTRL, {13'h0000, crc});
		wr(tcc_pkg::ADDR_TIMER_MODE, {14'h0000, mode});
	endtask : setup

	task wait_a(output int t);
		int n;
		n = na;
		for (int k = 0; k < 400 && na == n; k++) @(negedge clock);
		t = cyc;
	endtask : wait_a

	task finish_test();
		$display("checks=%0d mismatches=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rows = '{'{tcc_pkg::ADDR_PORT3_DIR, 16'h0000, 16'h00E0},
			'{tcc_pkg::ADDR_PORT3_DIR, 16'h001A, 16'h00FA},
			'{tcc_pkg::ADDR_PRESCALE, 16'h00FF, 16'h00F3},
			'{tcc_pkg::ADDR_CAP_CTRL, 16'h0007, 16'h0007},
			'{tcc_pkg::ADDR_CMP_A, 16'h1234, 16'h1234},
			'{tcc_pkg::ADDR_CMP_B, 16'hABCD, 16'hABCD},
			'{16'hFF70, 16'h5555, 16'h0000}};
		exp_e = '{16'h0001, 16'h0001, 16'h0000, 16'h0002};
		div = '{1, 4, 64};
		repeat (16) @(negedge clock);
		rst = 1'b0;
		rd(tcc_pkg::ADDR_PORT3_DIR, v0);
		chk(v0, 16'h00FF);
		chk({11'h000, out_en}, 16'h0000);
		for (i = 0; i < 7; i++) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, v0);
			chk(v0, rows[i].exp);
			if (rows[i].addr == tcc_pkg::ADDR_PORT3_DIR)
				chk({11'h000, out_en}, {11'h000, ~rows[i].exp[4:0]});
		end
		$display("test registers done");
		// Interval per internal clock select code, fx, fx/4 and fx/64
		wr(tcc_pkg::ADDR_CMP_A, 16'h0003);
		for (i = 0; i < 3; i++) begin
			setup(8'(i), 3'h0, 2'h2);
			wait_a(t0);
			wait_a(t1);
			chk(16'(t1 - t0), 16'(4 * div[i]));
		end
		$display("test interval done");
		// Pulse output on pin 30
		wr(tcc_pkg::ADDR_PORT3_DIR, 16'h00FE);
		chk({11'h000, out_en}, 16'h0001);
		wr(tcc_pkg::ADDR_CMP_A, 16'h0007);
		wr(tcc_pkg::ADDR_CMP_B, 16'h0002);
		setup(8'h00, 3'h0, 2'h3);
		prev = 1'b1;
		for (int k = 0; k < 40 && !(tout === 1'b1 && prev === 1'b0); k++) begin
			prev = tout;
			@(negedge clock);
		end
		h = 0;
		p = 0;
		prev = tout;
		repeat (64) begin
			@(negedge clock);
			h += (tout === 1'b1);
			p += (tout === 1'b1 && prev === 1'b0);
			prev = tout;
		end
		chk(16'(h), 16'd24);
		chk(16'(p), 16'd8);
		$display("test pulse done");
		// Free-running count and capture into B per edge code
		setup(8'h00, 3'h0, 2'h1);
		rd(tcc_pkg::ADDR_COUNT, v0);
		rd(tcc_pkg::ADDR_COUNT, v1);
		chk(v1 - v0, 16'h0002);
		for (i = 0; i < 4; i++) begin
			setup(8'(i << 4), 3'h4, 2'h1);
			b0 = nb;
			src.set_a(1'b1);
			t0 = cyc;
			repeat (10) @(negedge clock);
			rd(tcc_pkg::ADDR_CMP_B, v0);
			src.set_a(1'b0);
			t1 = cyc;
			repeat (10) @(negedge clock);
			rd(tcc_pkg::ADDR_CMP_B, v1);
			chk(16'(nb - b0), exp_e[i]);
			if (i == 3) chk(v1 - v0, 16'(t1 - t0));
		end
		// A one-cycle glitch is filtered out
		setup(8'h10, 3'h4, 2'h1);
		b0 = nb;
		src.set_a(1'b1);
		@(negedge clock);
		src.set_a(1'b0);
		repeat (12) @(negedge clock);
		chk(16'(nb - b0), 16'h0000);
		// Event counting on input-A rising edges, sampled at fx/8
		setup(8'h13, 3'h0, 2'h1);
		repeat (3) begin
			src.set_a(1'b1);
			repeat (40) @(negedge clock);
			src.set_a(1'b0);
			repeat (40) @(negedge clock);
		end
		rd(tcc_pkg::ADDR_COUNT, v0);
		chk(v0, 16'h0003);
		$display("test capture done");
		// Input B capture into A
		setup(8'h40, 3'h1, 2'h1);
		a0 = na;
		src.set_b(1'b1);
		repeat (12) @(negedge clock);
		src.set_b(1'b0);
		repeat (12) @(negedge clock);
		chk(16'(na - a0), 16'h0001);
		// Two-register capture, rising then reverse edge
		setup(8'h10, 3'h7, 2'h1);
		a0 = na;
		b0 = nb;
		src.set_a(1'b1);
		t0 = cyc;
		repeat (10) @(negedge clock);
		src.set_a(1'b0);
		t1 = cyc;
		repeat (12) @(negedge clock);
		rd(tcc_pkg::ADDR_CMP_A, v0);
		rd(tcc_pkg::ADDR_CMP_B, v1);
		chk(v0 - v1, 16'(t1 - t0));
		chk(16'(nb - b0), 16'h0001);
		chk(16'(na - a0), 16'h0000);
		// Both edges selected: A holds its value
		setup(8'h30, 3'h7, 2'h1);
		rd(tcc_pkg::ADDR_CMP_A, v0);
		src.set_a(1'b1);
		repeat (10) @(negedge clock);
		src.set_a(1'b0);
		repeat (12) @(negedge clock);
		rd(tcc_pkg::ADDR_CMP_A, v1);
		chk(v1, v0);
		$display("test two-register done");
		// Second reset in mid-run
		rst = 1'b1;
		repeat (16) @(negedge clock);
		rst = 1'b0;
		rd(tcc_pkg::ADDR_PORT3_DIR, v0);
		chk(v0, 16'h00FF);
		chk({15'h0000, tout}, 16'h0000);
		$display("test reset done");
		finish_test();
	end
endmodule : tb

// ### testbench/tcc_edge_src.sv
/*
 * Model of the external pulse sources on the two edge input pins.
 * Assumes the bench calls the setters just after a falling clock edge.
 */
`timescale 1ns/1ps
module tcc_edge_src (
	// Pin levels, push-pull driven
	output logic edge_a,
	output logic edge_b
);
	// Both sources idle low
	initial begin
		edge_a = 1'b0;
		edge_b = 1'b0;
	end

	// Level setters; pulse length is set by the caller
	task set_a(input logic v);
		edge_a = v;
	endtask : set_a

	task set_b(input logic v);
		edge_b = v;
	endtask : set_b
endmodule : tcc_edge_src
